// [pkg/txsg_pkg.sv]
// Shared constants and types for the transmit symbol generator and signal routing
package txsg_pkg;

    localparam int APB_AW = 8;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [7:0] OFS_SYM_A  = 8'h00;
    localparam logic [7:0] OFS_SYM_B  = 8'h04;
    localparam logic [7:0] OFS_SYM_C  = 8'h08;
    localparam logic [7:0] OFS_SYM_D  = 8'h0C;
    localparam logic [7:0] OFS_LEN    = 8'h10;
    localparam logic [7:0] OFS_BURST  = 8'h14;
    localparam logic [7:0] OFS_FRAME  = 8'h18;
    localparam logic [7:0] OFS_CFG_A  = 8'h1C;
    localparam logic [7:0] OFS_CFG_B  = 8'h20;
    localparam logic [7:0] OFS_ROUTE  = 8'h24;
    localparam logic [7:0] OFS_CTRL   = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;

    // Field positions
    localparam int LEN_A_LSB     = 0;
    localparam int LEN_B_LSB     = 4;
    localparam int BURST_EN_BIT  = 8;
    localparam int BURST_LVL_BIT = 9;
    localparam int FR_START_LSB  = 0;
    localparam int FR_STOP_LSB   = 2;
    localparam int CFG_PER_LSB   = 0;
    localparam int CFG_SUB_LSB   = 8;
    localparam int CFG_PULSE_LSB = 10;
    localparam int CFG_ENV_BIT   = 14;
    localparam int RT_OUT_LSB    = 0;
    localparam int RT_IN_LSB     = 4;
    localparam int RT_DRV_LSB    = 6;
    localparam int RT_CRX_BIT    = 8;
    localparam int CTRL_GO_BIT   = 0;
    localparam int CTRL_ACT_BIT  = 1;

    // Values after reset
    localparam logic [14:0] CFG_RST   = 15'h000F;
    localparam logic [8:0]  ROUTE_RST = 9'h000;

    // Signal-out selector codes
    localparam logic [3:0] OUT_LOW      = 4'h0;
    localparam logic [3:0] OUT_OBS_RX   = 4'h1;
    localparam logic [3:0] OUT_OBS_ANA  = 4'h2;
    localparam logic [3:0] OUT_OBS_DRV  = 4'h3;
    localparam logic [3:0] OUT_ENVELOPE = 4'h4;
    localparam logic [3:0] OUT_MAN_GEN  = 4'h6;
    localparam logic [3:0] OUT_MAN_SUB  = 4'h7;

    // Signal-in and driver source codes
    localparam logic [1:0] IN_OFF      = 2'h0;
    localparam logic [1:0] IN_INTERNAL = 2'h1;
    localparam logic [1:0] IN_EXT_A    = 2'h2;
    localparam logic [1:0] IN_EXT_GEN  = 2'h3;
    localparam logic [1:0] DRV_LOW     = 2'h0;
    localparam logic [1:0] DRV_INTERNAL = 2'h1;
    localparam logic [1:0] DRV_EXT     = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_SYM, ST_BURST, ST_DATA} txsg_state_e;

endpackage

// [rtl/txsg_bit_timer.sv]
// Bit-period divider producing a one-cycle tick per bit
`timescale 1ns/1ns
module txsg_bit_timer #(
    parameter int CNT_W = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             restart,
    input  wire logic [CNT_W-1:0] period,
    output logic                  tick,
    output logic      [CNT_W-1:0] phase
);
    import txsg_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } txsg_tmr_s;

    txsg_tmr_s s;
    txsg_tmr_s next_s;

    always_comb begin
        next_s = s;
        if (restart || s.cnt >= period) begin
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Restart suppresses the tick so a fresh bit always gets a full period
    assign tick  = !restart && (s.cnt >= period);
    assign phase = s.cnt;

endmodule

// [rtl/txsg_top.sv]
// Transmit symbol generator with signal-in/signal-out routing and APB registers
`timescale 1ns/1ns

// Behaviour
// - Four symbols; sym_a and sym_b hold 16-bit patterns plus optional burst of 1 to 256 bits.
// - sym_c and sym_d hold at most 8-bit patterns, no burst.
// - Pattern is sent from highest used bit down, LSB last.
// - Shared pair length bounds patterns; bits above it are ignored.
// - Frame control picks leading symbol a, b or c and trailing b, c or d.
// - Pairs a/b and c/d each share rate, subcarrier, pulse and envelope settings.
// - Signal-out selector 0100 drives the coded transmit envelope out when the active bit is set; it is low on the passive path.
// - Signal-in selector 01 internal receiver, 10 pin as Type A, 11 pin generic.
// - Signal-out selector 0110 gives Manchester generic, 0111 Manchester with subcarrier.
// - Passive and active antenna paths both supported, used one at a time.
// - Signal-out selector can expose internal transmit and receive signals.
module txsg_top #(
    parameter int PER_W = 8
) (
    input  wire logic                         core_clk,
    input  wire logic                         rstn,
    input  wire logic [txsg_pkg::APB_AW-1:0]  paddr,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [txsg_pkg::DATA_W-1:0]  pwdata,
    output logic      [txsg_pkg::DATA_W-1:0]  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         tx_bit_valid,
    input  wire logic                         tx_bit,
    input  wire logic                         tx_bit_last,
    output logic                              tx_bit_ready,
    input  wire logic                         ana_rx_data,
    input  wire logic                         ext_signal_in,
    input  wire logic                         man_generic,
    input  wire logic                         man_subcarrier,
    input  wire logic                         rx_request,
    output logic                              ext_signal_out,
    output logic                              driver_out,
    output logic                              rx_data,
    output logic                              rx_generic,
    output logic                              rx_enable,
    output logic                              frame_busy
);
    import txsg_pkg::*;

    typedef struct packed {
        logic [15:0]      sym_a;
        logic [15:0]      sym_b;
        logic [7:0]       sym_c;
        logic [7:0]       sym_d;
        logic [3:0]       len_a;
        logic [2:0]       len_b;
        logic [9:0]       burst;
        logic [3:0]       frame;
        logic [14:0]      cfg_a;
        logic [14:0]      cfg_b;
        logic [8:0]       route;
        logic             active;
        txsg_state_e      st;
        logic             post;
        logic [1:0]       sym;
        logic [3:0]       idx;
        logic [7:0]       bcnt;
        logic             cur_bit;
        logic             last;
        logic             restart;
        logic [7:0]       frames;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic             tx_bit_ready;
        logic             ext_signal_out;
        logic             driver_out;
        logic             rx_data;
        logic             rx_generic;
        logic             rx_enable;
        logic             busy;
    } txsg_regs_s;

    txsg_regs_s s;
    txsg_regs_s next_s;

    logic             tick;
    logic [PER_W-1:0] phase;
    logic [14:0]      cfg;
    logic             level;
    logic             env;
    logic             env_active;
    logic             env_passive;
    logic             sym_done;
    logic             wr_en;
    logic             rd_en;

    // Pattern of a symbol, c and d zero-extended to 16 bits; no masking by pair length
    function automatic logic [15:0] sym_pattern(input txsg_regs_s r, input logic [1:0] id);
        logic [15:0] p;
        p = 16'h0000;
        case (id)
            2'd0:    p = r.sym_a;
            2'd1:    p = r.sym_b;
            2'd2:    p = {8'h00, r.sym_c};
            default: p = {8'h00, r.sym_d};
        endcase
        return p;
    endfunction

    // Highest bit index sent for a symbol
    function automatic logic [3:0] sym_top(input txsg_regs_s r, input logic [1:0] id);
        return id[1] ? {1'b0, r.len_b} : r.len_a;
    endfunction

    function automatic logic [31:0] reg_read(input txsg_regs_s r, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            OFS_SYM_A:  d = {16'h0000, r.sym_a};
            OFS_SYM_B:  d = {16'h0000, r.sym_b};
            OFS_SYM_C:  d = {24'h000000, r.sym_c};
            OFS_SYM_D:  d = {24'h000000, r.sym_d};
            OFS_LEN:    d = {25'h0000000, r.len_b, r.len_a};
            OFS_BURST:  d = {22'h000000, r.burst};
            OFS_FRAME:  d = {28'h0000000, r.frame};
            OFS_CFG_A:  d = {17'h00000, r.cfg_a};
            OFS_CFG_B:  d = {17'h00000, r.cfg_b};
            OFS_ROUTE:  d = {23'h000000, r.route};
            OFS_CTRL:   d = {30'h00000000, r.active, 1'b0};
            OFS_STATUS: d = {8'h00, r.frames, 4'h0, r.idx, 1'b0, r.post,
                             r.sym, r.st, 1'b0, r.busy};
            default:    d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a, input logic wr);
        logic ok;
        ok = 1'b0;
        case (a)
            OFS_SYM_A, OFS_SYM_B, OFS_SYM_C, OFS_SYM_D, OFS_LEN, OFS_BURST,
            OFS_FRAME, OFS_CFG_A, OFS_CFG_B, OFS_ROUTE, OFS_CTRL: ok = 1'b1;
            OFS_STATUS: ok = !wr;
            default:    ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Data bits always use the a/b pair's timing (cfg_a)
    assign cfg = (s.st != ST_DATA && s.sym[1]) ? s.cfg_b : s.cfg_a;

    txsg_bit_timer #(
        .CNT_W (PER_W)
    ) u_timer (
        .core_clk (core_clk),
        .rstn     (rstn),
        .restart  (s.restart),
        .period   (cfg[CFG_PER_LSB +: PER_W]),
        .tick     (tick),
        .phase    (phase)
    );

    assign wr_en = psel && penable && s.pready && pwrite;
    assign rd_en = psel && penable && !s.pready;

    // Bit level before shaping
    always_comb begin
        level = 1'b0;
        case (s.st)
            ST_SYM:   level = 1'(sym_pattern(s, s.sym) >> s.idx);
            ST_BURST: level = s.burst[BURST_LVL_BIT];
            ST_DATA:  level = s.tx_bit_ready ? 1'b0 : s.cur_bit;
            default:  level = 1'b0;
        endcase
    end

    // Pulse length, subcarrier and envelope polarity of the active pair
    always_comb begin
        env = level;
        if (cfg[CFG_PULSE_LSB +: 4] != 4'h0 &&
            phase >= PER_W'(cfg[CFG_PULSE_LSB +: 4])) begin
            env = 1'b0;
        end
        if (cfg[CFG_SUB_LSB +: 2] != 2'h0) begin
            env = env && phase[cfg[CFG_SUB_LSB +: 2] - 2'd1];
        end
        if (s.st != ST_IDLE) begin
            env = env ^ cfg[CFG_ENV_BIT];
        end
        // One antenna path at a time: the target bit steers the frame
        env_active  = s.active && env;
        env_passive = !s.active && env;
    end

    always_comb begin
        next_s          = s;
        next_s.restart  = 1'b0;
        sym_done        = 1'b0;

        // APB slave: one wait state, write lands on the completing edge
        next_s.pready = rd_en;
        if (rd_en) begin
            next_s.prdata  = reg_read(s, paddr);
            next_s.pslverr = !addr_ok(paddr, pwrite);
        end else begin
            next_s.pslverr = 1'b0;
        end
        if (wr_en && addr_ok(paddr, 1'b1)) begin
            case (paddr)
                OFS_SYM_A: next_s.sym_a = pwdata[15:0];
                OFS_SYM_B: next_s.sym_b = pwdata[15:0];
                OFS_SYM_C: next_s.sym_c = pwdata[7:0];
                OFS_SYM_D: next_s.sym_d = pwdata[7:0];
                OFS_LEN: begin
                    next_s.len_a = pwdata[LEN_A_LSB +: 4];
                    next_s.len_b = pwdata[LEN_B_LSB +: 3];
                end
                OFS_BURST: next_s.burst = pwdata[9:0];
                OFS_FRAME: next_s.frame = pwdata[3:0];
                OFS_CFG_A: next_s.cfg_a = pwdata[14:0];
                OFS_CFG_B: next_s.cfg_b = pwdata[14:0];
                OFS_ROUTE: next_s.route = pwdata[8:0];
                OFS_CTRL: begin
                    // Target and start are ignored while a frame runs
                    if (s.st == ST_IDLE) begin
                        next_s.active = pwdata[CTRL_ACT_BIT];
                        if (pwdata[CTRL_GO_BIT]) begin
                            next_s.post    = 1'b0;
                            next_s.restart = 1'b1;
                            if (s.frame[FR_START_LSB +: 2] != 2'h0) begin
                                next_s.sym = s.frame[FR_START_LSB +: 2] - 2'd1;
                                next_s.idx = sym_top(s, s.frame[FR_START_LSB +: 2] - 2'd1);
                                next_s.st  = ST_SYM;
                            end else begin
                                next_s.st           = ST_DATA;
                                next_s.tx_bit_ready = 1'b1;
                            end
                        end
                    end
                end
                default: next_s.frame = s.frame;
            endcase
        end

        // Frame sequencer
        case (s.st)
            ST_SYM: begin
                if (tick) begin
                    if (s.idx == 4'h0) begin
                        if (!s.sym[1] && s.burst[BURST_EN_BIT]) begin
                            next_s.st   = ST_BURST;
                            next_s.bcnt = s.burst[7:0];
                        end else begin
                            sym_done = 1'b1;
                        end
                    end else begin
                        next_s.idx = s.idx - 4'h1;
                    end
                end
            end
            ST_BURST: begin
                if (tick) begin
                    if (s.bcnt == 8'h00) begin
                        sym_done = 1'b1;
                    end else begin
                        next_s.bcnt = s.bcnt - 8'h01;
                    end
                end
            end
            ST_DATA: begin
                if (s.tx_bit_ready) begin
                    if (tx_bit_valid) begin
                        next_s.cur_bit      = tx_bit;
                        next_s.last         = tx_bit_last;
                        next_s.tx_bit_ready = 1'b0;
                        next_s.restart      = 1'b1;
                    end
                end else if (tick) begin
                    if (s.last) begin
                        if (s.frame[FR_STOP_LSB +: 2] != 2'h0) begin
                            next_s.st      = ST_SYM;
                            next_s.post    = 1'b1;
                            next_s.sym     = s.frame[FR_STOP_LSB +: 2];
                            next_s.idx     = sym_top(s, s.frame[FR_STOP_LSB +: 2]);
                            next_s.restart = 1'b1;
                        end else begin
                            next_s.st     = ST_IDLE;
                            next_s.frames = s.frames + 8'h01;
                        end
                    end else begin
                        next_s.tx_bit_ready = 1'b1;
                    end
                end
            end
            default: next_s.bcnt = s.bcnt;
        endcase

        if (sym_done) begin
            if (s.post) begin
                next_s.st     = ST_IDLE;
                next_s.frames = s.frames + 8'h01;
            end else begin
                next_s.st           = ST_DATA;
                next_s.tx_bit_ready = 1'b1;
            end
        end
        next_s.busy = (next_s.st != ST_IDLE);

        // Receive path selection
        case (s.route[RT_IN_LSB +: 2])
            IN_INTERNAL: begin
                next_s.rx_data    = ana_rx_data;
                next_s.rx_generic = 1'b0;
            end
            IN_EXT_A: begin
                next_s.rx_data    = ext_signal_in;
                next_s.rx_generic = 1'b0;
            end
            IN_EXT_GEN: begin
                next_s.rx_data    = ext_signal_in;
                next_s.rx_generic = 1'b1;
            end
            default: begin
                next_s.rx_data    = 1'b0;
                next_s.rx_generic = 1'b0;
            end
        endcase
        next_s.rx_enable = s.route[RT_CRX_BIT] || rx_request;

        // Driver source
        case (s.route[RT_DRV_LSB +: 2])
            DRV_LOW:      next_s.driver_out = 1'b0;
            DRV_INTERNAL: next_s.driver_out = env_passive;
            DRV_EXT:      next_s.driver_out = ext_signal_in;
            default:      next_s.driver_out = 1'b0;
        endcase

        // Signal-out selector, including observation taps
        case (s.route[RT_OUT_LSB +: 4])
            OUT_ENVELOPE: next_s.ext_signal_out = env_active;
            OUT_MAN_GEN:  next_s.ext_signal_out = man_generic;
            OUT_MAN_SUB:  next_s.ext_signal_out = man_subcarrier;
            OUT_OBS_RX:   next_s.ext_signal_out = s.rx_data;
            OUT_OBS_ANA:  next_s.ext_signal_out = ana_rx_data;
            OUT_OBS_DRV:  next_s.ext_signal_out = s.driver_out;
            default:      next_s.ext_signal_out = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s       <= '0;
            s.cfg_a <= CFG_RST;
            s.cfg_b <= CFG_RST;
            s.route <= ROUTE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign prdata         = s.prdata;
    assign pready         = s.pready;
    assign pslverr        = s.pslverr;
    assign tx_bit_ready   = s.tx_bit_ready;
    assign ext_signal_out = s.ext_signal_out;
    assign driver_out     = s.driver_out;
    assign rx_data        = s.rx_data;
    assign rx_generic     = s.rx_generic;
    assign rx_enable      = s.rx_enable;
    assign frame_busy     = s.busy;
endmodule

// [testbench/txsg_far_end.sv]
// Behavioural remote front-end facing the signal-in and signal-out pins
`timescale 1ns/1ns
module txsg_far_end (
    input  wire logic core_clk,
    input  wire logic send_level,
    input  wire logic ext_signal_out,
    output logic      ext_signal_in,
    output logic      heard
);
    initial ext_signal_in = 1'b0;
    initial heard = 1'b0;
    // Remote flops add a cycle each way, as a real board would
    always @(posedge core_clk) begin
        ext_signal_in <= send_level;
        heard         <= ext_signal_out;
    end
endmodule

// [testbench/txsg_top_assertions.sv]
// Port checker for the symbol generator and routing block
`timescale 1ns/1ns
module txsg_top_assertions (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic [7:0] paddr,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       tx_bit_valid,
    input wire logic       tx_bit_ready,
    input wire logic       rx_request,
    input wire logic       rx_enable,
    input wire logic       frame_busy
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_apb_wait: assert property (s_access |=> s_answer)
        else $error("access not answered after one wait state");
    a_apb_idle: assert property (!psel |=> !pready)
        else $error("ready without a selected access");
    a_unmapped_err: assert property (pready && paddr > 8'h2C |-> pslverr)
        else $error("unmapped address not refused");
    a_status_ro: assert property (pready && pwrite && paddr == 8'h2C |-> pslverr)
        else $error("status write not refused");
    a_read_ok: assert property (pready && !pwrite && paddr <= 8'h2C
                                && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped read refused");
    a_bit_taken: assert property (tx_bit_valid && tx_bit_ready |=> !tx_bit_ready)
        else $error("ready held after a bit was taken");
    a_ready_framed: assert property (tx_bit_ready |-> frame_busy)
        else $error("data ready outside a frame");
    a_rx_follow: assert property (rx_request |=> rx_enable)
        else $error("receive request not followed");
endmodule
bind txsg_top txsg_top_assertions u_chk (
    .core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready),
    .rx_request(rx_request), .rx_enable(rx_enable), .frame_busy(frame_busy)
);

// [testbench/txsg_top_bench.sv]
// Self-checking bench for the symbol generator and routing block
`timescale 1ns/1ns
module txsg_top_bench;
    import txsg_pkg::*;
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, tx_bit_ready, ext_signal_out, driver_out;
    logic rx_data, rx_generic, rx_enable, frame_busy, ext_signal_in, heard;
    logic tx_bit_valid = 0, tx_bit = 0, tx_bit_last = 0, ana_rx_data = 0;
    logic man_generic = 0, man_subcarrier = 0, rx_request = 0, send_level = 0;
    int failures = 0, tests_run = 0;
    always #20 core_clk = ~core_clk;
    txsg_top u_txsg_top (.core_clk(core_clk), .rstn(rstn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit), .tx_bit_last(tx_bit_last),
        .tx_bit_ready(tx_bit_ready), .ana_rx_data(ana_rx_data),
        .ext_signal_in(ext_signal_in), .man_generic(man_generic),
        .man_subcarrier(man_subcarrier), .rx_request(rx_request),
        .ext_signal_out(ext_signal_out), .driver_out(driver_out),
        .rx_data(rx_data), .rx_generic(rx_generic), .rx_enable(rx_enable),
        .frame_busy(frame_busy));
    txsg_far_end u_txsg_far_end (.core_clk(core_clk), .send_level(send_level),
        .ext_signal_out(ext_signal_out), .ext_signal_in(ext_signal_in),
        .heard(heard));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic chk1(input logic seen, input logic want);
        check({31'h0, seen}, {31'h0, want});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Slave answers in its own time; only the watchdog ends a hung access
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk1(e, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, want);
    endtask
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        rd(OFS_CFG_A, 32'h0000000F);
        rd(OFS_CFG_B, 32'h0000000F);
        rd(OFS_ROUTE, 32'h0);
        wr(OFS_SYM_A, 32'h12345678);
        rd(OFS_SYM_A, 32'h00005678);
        wr(OFS_SYM_D, 32'h0000FFA6);
        rd(OFS_SYM_D, 32'h000000A6);
        wr(OFS_LEN, 32'h000000FF);
        rd(OFS_LEN, 32'h0000007F);
        apb(1'b0, 8'h30, 32'h0, q, e);
        chk1(e, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h1, q, e);
        chk1(e, 1'b1);
        $display("registers done");
    endtask
    task automatic t_route;
        logic [3:0] sel [3] = '{OUT_MAN_GEN, OUT_MAN_SUB, OUT_OBS_ANA};
        for (int i = 0; i < 3; i++) begin
            wr(OFS_ROUTE, {28'h0, sel[i]});
            {man_generic, man_subcarrier, ana_rx_data} <= 3'b100 >> i;
            repeat (4) @(posedge core_clk);
            chk1(ext_signal_out, 1'b1);
            {man_generic, man_subcarrier, ana_rx_data} <= ~(3'b100 >> i);
            repeat (4) @(posedge core_clk);
            chk1(ext_signal_out, 1'b0);
        end
        for (int k = 1; k < 4; k++) begin
            wr(OFS_ROUTE, (32'(k) << RT_IN_LSB) | 32'(OUT_OBS_RX));
            ana_rx_data <= 1'b1;
            send_level <= 1'b0;
            repeat (4) @(posedge core_clk);
            chk1(rx_data, k == 1);
            chk1(rx_generic, k == 3);
            chk1(ext_signal_out, k == 1);
            chk1(rx_enable, 1'b0);
            ana_rx_data <= 1'b0;
            send_level <= 1'b1;
            repeat (4) @(posedge core_clk);
            chk1(rx_data, k != 1);
        end
        $display("routing done");
    endtask
    task automatic t_drive;
        wr(OFS_ROUTE, 32'h0);
        rx_request <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk1(driver_out, 1'b0);
        chk1(rx_enable, 1'b1);
        rx_request <= 1'b0;
        wr(OFS_ROUTE, 32'h00000183);
        repeat (4) @(posedge core_clk);
        chk1(driver_out, 1'b1);
        chk1(rx_enable, 1'b1);
        chk1(ext_signal_out, 1'b1);
        send_level <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk1(driver_out, 1'b0);
        chk1(ext_signal_out, 1'b0);
        $display("driver source done");
    endtask
    task automatic run_frame(input logic [3:0] fr, input logic act, input logic [15:0] ex,
                             input int n, input logic [1:0] dat, input int nd);
        wr(OFS_FRAME, {28'h0, fr});
        wr(OFS_CTRL, {30'h0, act, 1'b1});
        fork
            begin
                for (int i = 0; i < nd; i++) begin
                    tx_bit_valid <= 1'b1;
                    tx_bit <= dat[nd-1-i];
                    tx_bit_last <= (i == nd - 1);
                    do @(posedge core_clk); while (tx_bit_ready !== 1'b1);
                end
                tx_bit_valid <= 1'b0;
            end
            begin
                wait (frame_busy === 1'b1);
                repeat (10) @(posedge core_clk);
                for (int i = 0; i < n; i++) begin
                    chk1(act ? heard : driver_out, ex[n-1-i]);
                    chk1(act ? driver_out : ext_signal_out, 1'b0);
                    repeat (16) @(posedge core_clk);
                end
            end
        join
        repeat (40) @(posedge core_clk);
        chk1(frame_busy, 1'b0);
    endtask
    task automatic t_frames;
        wr(OFS_LEN, 32'h00000051);
        wr(OFS_SYM_A, 32'h0000FFFE);
        wr(OFS_SYM_C, 32'h000000A6);
        wr(OFS_SYM_D, 32'h00000015);
        wr(OFS_BURST, 32'h00000301);
        wr(OFS_ROUTE, 32'h00000044);
        // Lead c, two data bits, trail d, on the active path
        run_frame(4'hF, 1'b1, 16'b10011010010101, 14, 2'b10, 2);
        // Lead a with burst, one data bit, trail c, on the passive path
        run_frame(4'h9, 1'b0, 16'b10110100110, 11, 2'b00, 1);
        $display("frames done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        t_regs();
        t_route();
        t_drive();
        t_frames();
        tally_and_finish();
    end
    // Whole run needs well under a tenth of this span
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end
endmodule
